// *** rsc_top.sv ***
// Reset merging, oscillator wait and stop release sequencer with AXI4-Lite registers.
//
// Operation
// [R01] Masked interrupt holds stop; unmasked releases; service needs enable and rank.
// [R02] After interrupt release wait 18 clocks for vectoring, else 12 clocks.
// [R03] Reset in stop mode releases stop then runs the normal reset sequence.
// [R04] External main clock skips the oscillation stabilization wait after reset.
// [R05] Internal reset comes from pin, watchdog, power-on clear and low voltage.
// [R06] Every reset restarts from the vector held at 0000H and 0001H.
// [R07] Pins are high impedance during reset and the following stabilization wait.
// [R08] Low pin level holds reset; high level leads to reset processing.
// [R09] Watchdog reset releases itself and restarts on the internal oscillator; the code keeps ctrl_ext_clock, so with it set the wait is skipped.
// [R10] Detector resets release once the supply is back above threshold.
// [R11] External source holds the pin low at least 10 microseconds.
// [R12] Oscillators stop and external clock input is ignored during reset.
// [R13] Reset ending stop keeps RAM while registers reinitialize, pins high impedance.
// [R14] Watchdog reset also reinitializes the watchdog timer.
// [R15] CPU clock is gated and peripherals stop during reset.
// [R16] Crystal and external clock pins act as input pins during reset.
// [R17] RAM keeps contents while supply stays above power-on clear level.
// [R18] Power-on clear runs in reset; low voltage stops unless it caused reset.
// [R19] All sources merge into one synchronized reset released after the wait.
`timescale 1ns/10ps
module rsc_top
    import rsc_pkg::*;
#(
    parameter int OSC_STAB_CYCLES = OSC_STAB_CYC,
    parameter int VECT_WAIT = RSC_VECT_WAIT,
    parameter int NOVECT_WAIT = RSC_NOVECT_WAIT
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reset_pin_n,
    input wire logic watchdog_overflow,
    input wire logic power_on_clear_detector,
    input wire logic low_voltage_detector,
    input wire logic interrupt_request,
    input wire logic interrupt_mask_flag,
    input wire logic service_rank_flag,
    input wire logic global_interrupt_allow,
    input wire logic in_service_level,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic system_reset,
    output logic stop_active,
    output logic fetch_vector,
    output logic [15:0] vector_addr_lo,
    output logic [15:0] vector_addr_hi,
    output logic resume_service,
    output logic resume_next,
    output rsc_ctl_t ctl
);

    // =====================================================================
    // Input synchronisers
    // =====================================================================
    logic [3:0] sync1;
    logic [3:0] sync2;
    wire [3:0] raw_src = {~reset_pin_n, watchdog_overflow, power_on_clear_detector,
                          low_voltage_detector};

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1 <= 4'hF;
            sync2 <= 4'hF;
        end
        else
        begin
            sync1 <= raw_src;
            sync2 <= sync1;
        end
    end

    logic irq_s1;
    logic irq_s2;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_s1 <= 1'b0;
            irq_s2 <= 1'b0;
        end
        else
        begin
            irq_s1 <= interrupt_request;
            irq_s2 <= irq_s1;
        end
    end

    // =====================================================================
    // Registers and source merge
    // =====================================================================
    logic ctrl_ext_clock;
    logic ctrl_stop_req;
    logic soft_reset;
    rsc_cause_t cause;

    wire pin_src = sync2[3];
    wire wdt_src = sync2[2];
    wire poc_src = sync2[1];
    wire lvi_src = sync2[0];
    wire any_src = pin_src | wdt_src | poc_src | lvi_src | soft_reset; // [R05] [R08] [R10]
    wire rsc_cause_t next_cause = any_src ? rsc_cause_t'(sync2) : cause;

    // =====================================================================
    // Reset sequencer
    // =====================================================================
    typedef enum logic [2:0] {
        ST_RESET,
        ST_PROC,
        ST_STAB,
        ST_RUN,
        ST_STOP,
        ST_WAKE
    } rsc_state_t;

    rsc_state_t state;
    rsc_state_t next_state;
    logic [31:0] count;
    logic [31:0] next_count;
    logic stopped_before;
    logic service_pending;
    rsc_wake_t wake;

    rsc_wake u_wake (
        .interrupt_mask_flag(interrupt_mask_flag),
        .service_rank_flag(service_rank_flag),
        .global_interrupt_allow(global_interrupt_allow),
        .in_service_level(in_service_level),
        .request(irq_s2),
        .outcome(wake)
    );

    wire proc_done = (count == 32'(RST_PROC_CYC - 1));
    wire stab_done = (count >= 32'(OSC_STAB_CYCLES - 1));
    wire wake_done = service_pending ? (count == 32'(VECT_WAIT - 1))
                                     : (count == 32'(NOVECT_WAIT - 1)); // [R02]

    always_comb
    begin
        next_state = state;
        next_count = count + 32'h1;
        unique case (state)
            ST_RESET:
            begin
                next_count = 32'h0;
                if (!any_src)
                    next_state = ST_PROC; // [R09] [R10] [R19]
            end
            ST_PROC:
            begin
                if (proc_done)
                begin
                    next_count = 32'h0;
                    next_state = ctrl_ext_clock ? ST_RUN : ST_STAB; // [R04]
                end
            end
            ST_STAB:
            begin
                if (stab_done)
                    next_state = ST_RUN; // [R19]
            end
            ST_RUN:
            begin
                next_count = 32'h0;
                if (ctrl_stop_req)
                    next_state = ST_STOP;
            end
            ST_STOP:
            begin
                next_count = 32'h0;
                if (wake != RSC_WAKE_HOLD)
                    next_state = ST_WAKE; // [R01]
            end
            ST_WAKE:
            begin
                if (wake_done)
                    next_state = ST_RUN;
            end
        endcase
        if (any_src)
        begin
            next_state = ST_RESET; // [R03]
            next_count = 32'h0;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ST_RESET;
            count <= 32'h0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            service_pending <= 1'b0;
        else if (state == ST_STOP)
            service_pending <= (wake == RSC_WAKE_SERVICE); // [R01]
    end

    // Remember a reset that ended stop mode so RAM retention is reported.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            stopped_before <= 1'b0;
        else if (state == ST_STOP && any_src)
            stopped_before <= 1'b1; // [R13]
        else if (state == ST_RUN)
            stopped_before <= 1'b0;
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    // Controls follow the next state so that they line up with system_reset.
    wire in_reset = (next_state == ST_RESET) || (next_state == ST_PROC);
    wire in_stab = (state == ST_STAB);
    wire next_stab = (next_state == ST_STAB);
    rsc_ctl_t next_ctl;

    always_comb
    begin
        next_ctl.cpu_clock_gate = in_reset | next_stab; // [R15]
        next_ctl.peripherals_stop = in_reset; // [R15]
        next_ctl.pins_hiz = in_reset | next_stab; // [R07] [R13]
        next_ctl.osc_stop = (next_state == ST_RESET); // [R12]
        next_ctl.clock_pins_input = in_reset; // [R16]
        next_ctl.ram_retain = ~poc_src; // [R17]
        next_ctl.watchdog_clear = in_reset & next_cause.watchdog; // [R14]
        next_ctl.low_voltage_keep = ~in_reset | next_cause.low_voltage; // [R18]
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctl <= '{default: 1'b1};
            system_reset <= 1'b1;
            stop_active <= 1'b0;
            fetch_vector <= 1'b0;
            resume_service <= 1'b0;
            resume_next <= 1'b0;
        end
        else
        begin
            ctl <= next_ctl;
            system_reset <= (next_state != ST_RUN) && (next_state != ST_STOP)
                            && (next_state != ST_WAKE); // [R19]
            stop_active <= (next_state == ST_STOP);
            fetch_vector <= (state != ST_RUN) && (state != ST_WAKE)
                            && (next_state == ST_RUN); // [R06]
            resume_service <= (state == ST_WAKE) && (next_state == ST_RUN) && service_pending;
            resume_next <= (state == ST_WAKE) && (next_state == ST_RUN) && !service_pending;
        end
    end

    assign vector_addr_lo = RESET_VECTOR_LO; // [R06]
    assign vector_addr_hi = RESET_VECTOR_HI; // [R06]

    // =====================================================================
    // Cause capture
    // =====================================================================
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            cause <= '0;
        else
            cause <= next_cause; // [R05]
    end

    // =====================================================================
    // AXI4-Lite slave
    // =====================================================================
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire have_aw = aw_held || aw_fire;
    wire have_w = w_held || w_fire;
    wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
    wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
    wire do_write = have_aw && have_w && !s_axi_bvalid;
    wire wr_ctrl = do_write && (wr_addr == RSC_CTRL_ADDR) && wr_strb[0];
    wire wr_known = (wr_addr == RSC_CTRL_ADDR);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end
        else
        begin
            aw_held <= have_aw && !do_write;
            w_held <= have_w && !do_write;
            if (aw_fire)
                aw_addr <= s_axi_awaddr;
            if (w_fire)
            begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? AXI_OKAY : AXI_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Control bits; the stop request clears itself once stop is entered.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_ext_clock <= 1'b0;
            ctrl_stop_req <= 1'b0;
            soft_reset <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            ctrl_ext_clock <= wr_data[CTRL_XTAL_BIT];
            ctrl_stop_req <= wr_data[CTRL_STOP_BIT];
            soft_reset <= wr_data[CTRL_SWRST_BIT];
        end
        else
        begin
            soft_reset <= 1'b0;
            if (state == ST_STOP || any_src)
                ctrl_stop_req <= 1'b0;
        end
    end

    wire [31:0] rd_ctrl = {29'h0, soft_reset, ctrl_stop_req, ctrl_ext_clock};
    wire [31:0] rd_stat = {26'h0, state == ST_WAKE, stopped_before, in_stab,
                           stop_active, system_reset, service_pending};
    wire [31:0] rd_cause = {28'h0, cause.pin, cause.watchdog, cause.power_on,
                            cause.low_voltage};
    wire rd_known = (s_axi_araddr == RSC_CTRL_ADDR) || (s_axi_araddr == RSC_STAT_ADDR)
                    || (s_axi_araddr == RSC_CAUSE_ADDR);
    wire [31:0] rd_mux = (s_axi_araddr == RSC_CTRL_ADDR) ? rd_ctrl :
                         (s_axi_araddr == RSC_STAT_ADDR) ? rd_stat :
                         (s_axi_araddr == RSC_CAUSE_ADDR) ? rd_cause : 32'h0;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= AXI_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_known ? AXI_OKAY : AXI_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule : rsc_top

// *** rsc_pkg.sv ***
// Package of constants and types for the reset and stop release control block.
package rsc_pkg;

    // =====================================================================
    // Register map
    // =====================================================================
    localparam logic [7:0] RSC_CTRL_ADDR = 8'h00;
    localparam logic [7:0] RSC_STAT_ADDR = 8'h04;
    localparam logic [7:0] RSC_CAUSE_ADDR = 8'h08;

    localparam int CTRL_XTAL_BIT = 0;
    localparam int CTRL_STOP_BIT = 1;
    localparam int CTRL_SWRST_BIT = 2;

    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    localparam logic [15:0] RESET_VECTOR_LO = 16'h0000;
    localparam logic [15:0] RESET_VECTOR_HI = 16'h0001;

    // =====================================================================
    // Timing
    // =====================================================================
    localparam int CLK_MHZ = 100;
    localparam int RSC_VECT_WAIT = 18;
    localparam int RSC_NOVECT_WAIT = 12;
    localparam int OSC_STAB_US = 410;
    localparam int OSC_STAB_CYC = OSC_STAB_US * CLK_MHZ;
    localparam int RST_PROC_CYC = 4;

    // =====================================================================
    // Types
    // =====================================================================
    typedef enum logic [1:0] {
        RSC_WAKE_HOLD,
        RSC_WAKE_NEXT,
        RSC_WAKE_SERVICE
    } rsc_wake_t;

    typedef struct packed {
        logic pin;
        logic watchdog;
        logic power_on;
        logic low_voltage;
    } rsc_cause_t;

    typedef struct packed {
        logic cpu_clock_gate;
        logic peripherals_stop;
        logic pins_hiz;
        logic osc_stop;
        logic clock_pins_input;
        logic ram_retain;
        logic watchdog_clear;
        logic low_voltage_keep;
    } rsc_ctl_t;

endpackage : rsc_pkg

// *** rsc_wake.sv ***
// Decision logic for an interrupt request seen during stop mode.
`timescale 1ns/10ps
module rsc_wake
    import rsc_pkg::*;
(
    input wire logic interrupt_mask_flag,
    input wire logic service_rank_flag,
    input wire logic global_interrupt_allow,
    input wire logic in_service_level,
    input wire logic request,
    output rsc_wake_t outcome
);
    wire rank_ok = ~service_rank_flag | in_service_level;
    wire serve = global_interrupt_allow & rank_ok;
    // A masked request leaves stop in place, else serve or continue.
    assign outcome = (!request || interrupt_mask_flag) ? RSC_WAKE_HOLD :
                     serve ? RSC_WAKE_SERVICE : RSC_WAKE_NEXT; // [R01]
endmodule : rsc_wake

// *** rsc_reset_src.sv ***
// Model of the reset pin driver and the on-chip reset requesters.
`timescale 1ns/10ps
module rsc_reset_src
#(
    parameter int MIN_LOW = 1000
)
(
    input wire logic clk,
    output logic reset_pin_n,
    output logic watchdog_overflow,
    output logic power_on_clear_detector,
    output logic low_voltage_detector
);
    initial
    begin
        reset_pin_n = 1'b1;
        watchdog_overflow = 1'b0;
        power_on_clear_detector = 1'b0;
        low_voltage_detector = 1'b0;
    end

    // Asserts source k (pin, watchdog, power-on clear, low voltage) for n cycles, the pin for at least MIN_LOW cycles.
    task automatic hold(input int k, input int n);
        int len;
        len = (k == 0 && n < MIN_LOW) ? MIN_LOW : n;
        case (k)
            0: reset_pin_n <= 1'b0;
            1: watchdog_overflow <= 1'b1;
            2: power_on_clear_detector <= 1'b1;
            default: low_voltage_detector <= 1'b1;
        endcase
        repeat (len) @(posedge clk);
        reset_pin_n <= 1'b1;
        watchdog_overflow <= 1'b0;
        power_on_clear_detector <= 1'b0;
        low_voltage_detector <= 1'b0;
    endtask : hold
endmodule : rsc_reset_src

// *** rsc_top_asserts.sv ***
// Concurrent checks on the ports of the reset and stop release block.
`timescale 1ns/10ps
module rsc_top_asserts
    import rsc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reset_pin_n,
    input wire logic watchdog_overflow,
    input wire logic power_on_clear_detector,
    input wire logic low_voltage_detector,
    input wire logic interrupt_request,
    input wire logic interrupt_mask_flag,
    input wire logic service_rank_flag,
    input wire logic global_interrupt_allow,
    input wire logic in_service_level,
    input wire logic system_reset,
    input wire logic stop_active,
    input wire logic fetch_vector,
    input wire logic [15:0] vector_addr_lo,
    input wire logic [15:0] vector_addr_hi,
    input wire logic resume_service,
    input wire logic resume_next,
    input wire rsc_ctl_t ctl
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // =====================================================================
    // Helper terms
    // =====================================================================
    wire quiet = reset_pin_n & ~watchdog_overflow & ~power_on_clear_detector
        & ~low_voltage_detector;
    wire svc = global_interrupt_allow & (~service_rank_flag | in_service_level);
    wire wake = stop_active & ~interrupt_mask_flag & quiet;

    // =====================================================================
    // Assertions
    // =====================================================================
    AST_SRC_RESET: assert property (!quiet [*6] |-> system_reset)
        else $error("reset source did not raise system reset");
    AST_PIN_HOLD: assert property ($fell(reset_pin_n) |-> ##[3:6] system_reset)
        else $error("reset pin low did not reset");
    AST_HIZ: assert property (system_reset |-> ctl.pins_hiz && ctl.cpu_clock_gate)
        else $error("pins or cpu clock active in reset");
    AST_OSC: assert property (!quiet [*6] |-> ctl.osc_stop && ctl.clock_pins_input
        && ctl.peripherals_stop)
        else $error("oscillators running in reset");
    AST_WD_CLR: assert property (watchdog_overflow [*6] |-> ctl.watchdog_clear)
        else $error("watchdog not cleared");
    AST_LVI_KEEP: assert property (low_voltage_detector [*6] |-> ctl.low_voltage_keep)
        else $error("low voltage detector stopped");
    AST_RAM: assert property (!power_on_clear_detector [*6] |-> ctl.ram_retain)
        else $error("ram not retained");
    AST_VECTOR: assert property (fetch_vector |-> vector_addr_lo == 16'h0000
        && vector_addr_hi == 16'h0001 && !system_reset)
        else $error("bad restart vector");
    AST_FETCH: assert property ($fell(system_reset) |-> ##[0:2] fetch_vector)
        else $error("no restart after reset");
    AST_HOLD: assert property ((stop_active && interrupt_mask_flag && quiet) [*3]
        |=> stop_active)
        else $error("masked request left stop");
    AST_NEXT: assert property ($rose(interrupt_request) && wake && !svc
        |-> ##[12:18] resume_next)
        else $error("late resume to next");
    AST_SERVICE: assert property ($rose(interrupt_request) && wake && svc
        |-> ##[18:24] resume_service)
        else $error("late resume to service");
    AST_STOP_RST: assert property ($fell(reset_pin_n) && stop_active
        |-> ##[1:6] !stop_active)
        else $error("reset did not end stop");

    cover property (resume_next);
    cover property (resume_service);
    cover property (fetch_vector);
endmodule : rsc_top_asserts

bind rsc_top rsc_top_asserts u_rsc_chk (.*);

// *** rsc_top_tb.sv ***
// Self-checking bench for the reset and stop release block.
`timescale 1ns/10ps
module rsc_top_tb
    import rsc_pkg::*;
();
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic reset_pin_n, watchdog_overflow, power_on_clear_detector, low_voltage_detector;
    logic interrupt_request = 1'b0;
    logic interrupt_mask_flag = 1'b0, service_rank_flag = 1'b0;
    logic global_interrupt_allow = 1'b0, in_service_level = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic system_reset, stop_active, fetch_vector, resume_service, resume_next;
    logic [15:0] vector_addr_lo, vector_addr_hi;
    rsc_ctl_t ctl;
    int n_mismatch = 0, checks_done = 0, cyc = 0, nf = 0, nn = 0, ns = 0;

    always #5 clk = ~clk;
    rsc_top #(.OSC_STAB_CYCLES(20)) dut (.*);
    rsc_reset_src src (.*);

    // =====================================================================
    // Pulse counters and timeout
    // =====================================================================
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        nf <= nf + int'(fetch_vector === 1'b1);
        nn <= nn + int'(resume_next === 1'b1);
        ns <= ns + int'(resume_service === 1'b1);
        if (cyc == 20000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    // =====================================================================
    // Shared tasks
    // =====================================================================
    task automatic complete_run();
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask : axi_rd

    task automatic rst_len(output int n);
        n = 0;
        while (system_reset !== 1'b0)
        begin
            @(posedge clk);
            n++;
        end
        repeat (3) @(posedge clk);
    endtask : rst_len

    // =====================================================================
    // Scenarios
    // =====================================================================
    task automatic t_boot();
        int n;
        rst_len(n);
        chk(nf, 1);
        chk({vector_addr_hi, vector_addr_lo}, 32'h00010000);
        chk(ctl.pins_hiz, 1'b0);
    endtask : t_boot

    task automatic t_axi();
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(8'h0C, d, r);
        chk(r, AXI_SLVERR);
        chk(d, 32'h00000000);
        axi_wr(8'h10, 32'h00000007, r);
        chk(r, AXI_SLVERR);
        axi_wr(RSC_CTRL_ADDR, 32'h00000001, r);
        axi_rd(RSC_CTRL_ADDR, d, r);
        chk(d[0], 1'b1);
    endtask : t_axi

    task automatic t_skip();
        logic [1:0] r;
        int n, f;
        src.hold(1, 10);
        rst_len(n);
        chk(n < 20, 1'b1);
        f = nf;
        axi_wr(RSC_CTRL_ADDR, 32'h00000004, r);
        rst_len(n);
        chk(n >= 20, 1'b1);
        chk(nf - f, 1);
    endtask : t_skip

    task automatic t_src();
        logic [31:0] d;
        logic [1:0] r;
        int n, f;
        for (int k = 0; k < 4; k++)
        begin
            f = nf;
            src.hold(k, 10);
            rst_len(n);
            chk(n >= 24, 1'b1);
            chk(nf - f, 1);
            axi_rd(RSC_CAUSE_ADDR, d, r);
            chk(d[3 - k], 1'b1);
        end
    endtask : t_src

    task automatic t_wake();
        logic [3:0] row [6] = '{4'h0, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8};
        int want [6] = '{1, 2, 1, 1, 2, 0};
        logic [1:0] r;
        int a, b;
        for (int i = 0; i < 6; i++)
        begin
            axi_wr(RSC_CTRL_ADDR, 32'h00000002, r);
            while (stop_active !== 1'b1)
                @(posedge clk);
            {interrupt_mask_flag, service_rank_flag} <= row[i][3:2];
            {global_interrupt_allow, in_service_level} <= row[i][1:0];
            a = nn;
            b = ns;
            repeat (2) @(posedge clk);
            interrupt_request <= 1'b1;
            repeat (40) @(posedge clk);
            interrupt_request <= 1'b0;
            chk(nn - a + 2 * (ns - b), want[i]);
            chk(stop_active, i == 5);
        end
    endtask : t_wake

    task automatic t_stop_rst();
        int n, f;
        f = nf;
        src.hold(0, 10);
        chk(stop_active, 1'b0);
        chk(ctl.ram_retain, 1'b1);
        chk(ctl.low_voltage_keep, 1'b0);
        rst_len(n);
        chk(nf - f, 1);
        interrupt_mask_flag <= 1'b0;
    endtask : t_stop_rst

    initial
    begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        t_boot();
        t_axi();
        t_skip();
        t_src();
        t_wake();
        t_stop_rst();
        complete_run();
    end
endmodule : rsc_top_tb
